// ### rtl/sync_out_defines.svh
// register offsets, field positions and reset values of the sync output
`ifndef SYNC_OUT_DEFINES_SVH
`define SYNC_OUT_DEFINES_SVH

// *****************************************************************
// register byte offsets
// *****************************************************************
`define OFF_DELAY_D2_D1 8'h21
`define OFF_DELAY_D0 8'h22
`define OFF_CLOCK_KILL 8'h27
`define OFF_PAD_DRIVE 8'h28
`define OFF_PAD_CTRL 8'h29
`define OFF_DATA_EN_HI 8'h2A
`define OFF_DATA_EN_LO 8'h2B
`define OFF_DELAY_LS_D11 8'h2C
`define OFF_DELAY_D10_D9 8'h2D
`define OFF_DELAY_D8_D7 8'h2E
`define OFF_DELAY_D6_D5 8'h2F
`define OFF_DELAY_D4_D3 8'h30
`define OFF_START_ROW_H 8'h69
`define OFF_START_ROW_L 8'h6A
`define OFF_STOP_ROW_H 8'h6B
`define OFF_STOP_ROW_L 8'h6C
`define OFF_START_COL_H 8'h6D
`define OFF_START_COL_L 8'h6E
`define OFF_SUPPRESS 8'h86
`define OFF_SYNC_MODE 8'h87
`define OFF_STATUS 8'hF0

// *****************************************************************
// writable bits of each register
// *****************************************************************
`define MASK_DELAY_PAIR 8'h77
`define MASK_DELAY_HI 8'h70
`define MASK_CLOCK_KILL 8'h08
`define MASK_FULL 8'hFF
`define MASK_PAD_CTRL 8'hFE
`define MASK_DATA_EN_LO 8'hF0
`define MASK_HIGH_PART 8'h1F
`define MASK_SUPPRESS 8'h60
`define MASK_SYNC_MODE 8'h70

// *****************************************************************
// reset values
// *****************************************************************
`define RST_ZERO 8'h00
`define RST_START_ROW_L 8'h0D
`define RST_STOP_ROW_H 8'h03
`define RST_STOP_ROW_L 8'hDD
`define RST_START_COL_L 8'h02

// *****************************************************************
// field positions
// *****************************************************************
`define BIT_CLOCK_KILL 3
`define BIT_FS_EN 7
`define LSB_LS_DRIVE 5
`define BIT_LS_EN 4
`define BIT_PCLK_EN 3
`define BIT_PCLK_INV 2
`define BIT_SWAP 1
`define LSB_DATA_DRIVE 6
`define LSB_PCLK_DRIVE 4
`define LSB_PCLK_DELAY 0
`define LSB_DELAY_HI 4
`define LSB_DELAY_LO 0
`define LSB_SUPPRESS 5
`define BIT_FS_INV 6
`define BIT_IN_BLANK 5
`define BIT_LS_INV 4

// *****************************************************************
// frame geometry and pad delay steps
// *****************************************************************
`define FRAME_LAST_COL_DEF 13'h0B99
`define FRAME_LAST_ROW_DEF 13'h03E7
`define LINE_ACTIVE_COLS_DEF 13'h0510
`define LS_DELAY_STEP_PS 800
`define PCLK_DELAY_STEP_PS 400

`endif

// ### rtl/sync_out_pkg.sv
// types shared by the parallel sync output block
package sync_out_pkg;

    typedef struct packed {
        logic [12:0] start_row;
        logic [12:0] stop_row;
        logic [12:0] start_col;
        logic [1:0] suppress;
        logic in_blank;
        logic fs_inv;
        logic ls_inv;
    } sync_cfg_s;

    typedef struct packed {
        logic [1:0] data_strength;
        logic [1:0] pixclk_strength;
        logic [1:0] line_sync_strength;
        logic [3:0] pixclk_delay;
        logic [2:0] line_sync_delay;
        logic [11:0][2:0] data_delay;
    } pad_ctrl_s;

endpackage

// ### rtl/parallel_sync_output.sv
// parallel video sync generator, pad controls and pixel buffer
`timescale 1ns/1ns
`default_nettype none
`include "sync_out_defines.svh"
// Contract
// - frame sync spans start row to stop row, 13-bit split high/low values
// - frame sync begins at programmable start column, default column 2
// - suppress field: 0 none, 1 frame, 2 line, 3 both syncs
// - all-lines bit allows line sync in vertical blanking, else inactive
// - separate invert bits for frame and line sync, cleared at reset
// - output is frame sync, line sync, pixel clock and 12-bit data
// - frame, line and clock pads each have enable, cleared at reset
// - twelve data pad enables, bits 11-4 one byte, 3-0 next upper nibble
// - swap bit reverses the data bit order across the pads
// - 3-bit line sync delay setting, fixed step per count
// - 4-bit pixel clock delay setting, half the line sync step
// - per data pad 3-bit delay fields, two per byte, reset zero
// - 2-bit drive strengths for data, line sync and clock pads
// - kill bit stops the clock at its output pad
// - column counts per pixel clock, row steps on column wrap
// - sync settings take effect at last line of the frame

// *****************************************************************
// pixel buffer
// *****************************************************************
module pixel_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // depth must be a power of two: the wrap bit tells full from empty
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire same_slot = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = !(same_slot && (wr_ptr[AW] != rd_ptr[AW]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + (AW+1)'(1);
            if (pop)
                rd_ptr <= rd_ptr + (AW+1)'(1);
        end
    end
endmodule

// *****************************************************************
// sync generator and pad control
// *****************************************************************
module parallel_sync_output #(
    parameter logic [12:0] FRAME_LAST_COL = `FRAME_LAST_COL_DEF,
    parameter logic [12:0] FRAME_LAST_ROW = `FRAME_LAST_ROW_DEF,
    parameter logic [12:0] LINE_ACTIVE_COLS = `LINE_ACTIVE_COLS_DEF,
    parameter int FIFO_DEPTH = 8
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    // pixel clock pin from the sensor timing domain
    input wire logic pixclk_in,
    // pixel stream from the image pipe
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [11:0] pix_data,
    // video pads
    output logic frame_sync_pin,
    output logic frame_sync_pin_oe,
    output logic line_sync_pin,
    output logic line_sync_pin_oe,
    output logic pixclk_pin,
    output logic pixclk_pin_oe,
    output logic [11:0] data_pin,
    output logic [11:0] data_pin_oe,
    // analog pad settings
    output sync_out_pkg::pad_ctrl_s pad_ctrl
);
    localparam int SLOTS = 20;
    localparam logic [7:0] SLOT_ADDR [SLOTS] = '{
        `OFF_DELAY_D2_D1, `OFF_DELAY_D0, `OFF_CLOCK_KILL, `OFF_PAD_DRIVE,
        `OFF_PAD_CTRL, `OFF_DATA_EN_HI, `OFF_DATA_EN_LO, `OFF_DELAY_LS_D11,
        `OFF_DELAY_D10_D9, `OFF_DELAY_D8_D7, `OFF_DELAY_D6_D5,
        `OFF_DELAY_D4_D3, `OFF_START_ROW_H, `OFF_START_ROW_L,
        `OFF_STOP_ROW_H, `OFF_STOP_ROW_L, `OFF_START_COL_H,
        `OFF_START_COL_L, `OFF_SUPPRESS, `OFF_SYNC_MODE};
    localparam logic [7:0] SLOT_MASK [SLOTS] = '{
        `MASK_DELAY_PAIR, `MASK_DELAY_HI, `MASK_CLOCK_KILL, `MASK_FULL,
        `MASK_PAD_CTRL, `MASK_FULL, `MASK_DATA_EN_LO, `MASK_DELAY_PAIR,
        `MASK_DELAY_PAIR, `MASK_DELAY_PAIR, `MASK_DELAY_PAIR,
        `MASK_DELAY_PAIR, `MASK_HIGH_PART, `MASK_FULL, `MASK_HIGH_PART,
        `MASK_FULL, `MASK_HIGH_PART, `MASK_FULL, `MASK_SUPPRESS,
        `MASK_SYNC_MODE};
    localparam logic [7:0] SLOT_RST [SLOTS] = '{
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_START_ROW_L, `RST_STOP_ROW_H, `RST_STOP_ROW_L,
        `RST_ZERO, `RST_START_COL_L, `RST_ZERO, `RST_ZERO};

    // *****************************************************************
    // register file
    // *****************************************************************
    logic [7:0] regs [SLOTS];
    logic [7:0] rd_chain [SLOTS+1];
    logic [SLOTS-1:0] slot_hit;

    assign rd_chain[0] = 8'h00;
    for (genvar i = 0; i < SLOTS; i++)
    begin : g_slot
        assign slot_hit[i] = (reg_addr == SLOT_ADDR[i]);
        assign rd_chain[i+1] = rd_chain[i] | (slot_hit[i] ? regs[i] : 8'h00);
        always_ff @(posedge core_clk)
        begin
            if (srst)
                regs[i] <= SLOT_RST[i];
            else if (reg_write && slot_hit[i])
                regs[i] <= reg_wdata & SLOT_MASK[i];
        end
    end

    wire [7:0] pad_bits = regs[4];
    wire [7:0] mode_bits = regs[19];
    wire clock_kill = regs[2][`BIT_CLOCK_KILL];
    wire pclk_invert = pad_bits[`BIT_PCLK_INV];
    wire swap = pad_bits[`BIT_SWAP];

    // values as software sees them, waiting for the last line of the frame
    sync_out_pkg::sync_cfg_s next_work;
    sync_out_pkg::sync_cfg_s work;
    assign next_work.start_row = {regs[12][4:0], regs[13]};
    assign next_work.stop_row = {regs[14][4:0], regs[15]};
    assign next_work.start_col = {regs[16][4:0], regs[17]};
    assign next_work.suppress = regs[18][`LSB_SUPPRESS +: 2];
    assign next_work.in_blank = mode_bits[`BIT_IN_BLANK];
    assign next_work.fs_inv = mode_bits[`BIT_FS_INV];
    assign next_work.ls_inv = mode_bits[`BIT_LS_INV];

    // *****************************************************************
    // pad settings
    // *****************************************************************
    assign pad_ctrl.data_strength = regs[3][`LSB_DATA_DRIVE +: 2];
    assign pad_ctrl.pixclk_strength = regs[3][`LSB_PCLK_DRIVE +: 2];
    assign pad_ctrl.line_sync_strength = pad_bits[`LSB_LS_DRIVE +: 2];
    assign pad_ctrl.pixclk_delay = regs[3][`LSB_PCLK_DELAY +: 4];
    assign pad_ctrl.line_sync_delay = regs[7][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[11] = regs[7][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[10] = regs[8][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[9] = regs[8][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[8] = regs[9][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[7] = regs[9][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[6] = regs[10][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[5] = regs[10][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[4] = regs[11][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[3] = regs[11][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[2] = regs[0][`LSB_DELAY_HI +: 3];
    assign pad_ctrl.data_delay[1] = regs[0][`LSB_DELAY_LO +: 3];
    assign pad_ctrl.data_delay[0] = regs[1][`LSB_DELAY_HI +: 3];

    // pads are released, never driven, until software enables them
    assign frame_sync_pin_oe = pad_bits[`BIT_FS_EN];
    assign line_sync_pin_oe = pad_bits[`BIT_LS_EN];
    assign pixclk_pin_oe = pad_bits[`BIT_PCLK_EN];
    assign data_pin_oe = {regs[5], regs[6][7:4]};

    // *****************************************************************
    // pixel clock sampling
    // *****************************************************************
    logic pclk_meta;
    logic pclk_sync;
    logic pclk_prev;
    wire pclk_rise = pclk_sync && !pclk_prev;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pclk_meta <= 1'b0;
            pclk_sync <= 1'b0;
            pclk_prev <= 1'b0;
        end
        else
        begin
            pclk_meta <= pixclk_in;
            pclk_sync <= pclk_meta;
            pclk_prev <= pclk_sync;
        end
    end

    // *****************************************************************
    // frame counters
    // *****************************************************************
    logic [12:0] col;
    logic [12:0] row;
    wire col_wrap = (col == FRAME_LAST_COL);
    wire row_wrap = (row == FRAME_LAST_ROW);
    wire cfg_load = pclk_rise && row_wrap && (col == 13'h0000);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            col <= 13'h0000;
            row <= 13'h0000;
        end
        else if (pclk_rise)
        begin
            col <= col_wrap ? 13'h0000 : col + 13'h0001;
            if (col_wrap)
                row <= row_wrap ? 13'h0000 : row + 13'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            work <= {5'h00, `RST_START_ROW_L, 5'(`RST_STOP_ROW_H),
                     `RST_STOP_ROW_L, 5'h00, `RST_START_COL_L, 5'h00};
        else if (cfg_load)
            work <= next_work;
    end

    // *****************************************************************
    // sync shaping
    // *****************************************************************
    wire [25:0] pos = {row, col};
    wire [25:0] fs_begin = {work.start_row, work.start_col};
    wire fs_raw = (pos >= fs_begin) && (row <= work.stop_row);
    wire vblank = (row < work.start_row) || (row > work.stop_row);
    wire [12:0] line_stop = work.start_col + LINE_ACTIVE_COLS;
    wire ls_raw = (col >= work.start_col) && (col < line_stop);
    wire active_pix = ls_raw && !vblank;
    wire ls_gated = ls_raw && (!vblank || work.in_blank);
    // suppression first, so a dropped sync still rests at its idle level
    wire fs_kept = fs_raw && !work.suppress[0];
    wire ls_kept = ls_gated && !work.suppress[1];
    wire next_fs = fs_kept ^ work.fs_inv;
    wire next_ls = ls_kept ^ work.ls_inv;

    // *****************************************************************
    // pixel path
    // *****************************************************************
    logic fifo_valid;
    logic [11:0] fifo_data;
    logic [11:0] data_rev;
    wire fifo_take = pclk_rise && active_pix;

    for (genvar b = 0; b < 12; b++)
    begin : g_rev
        assign data_rev[b] = fifo_data[11-b];
    end

    pixel_fifo #(
        .WIDTH(12),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(pix_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    wire [11:0] next_data = swap ? data_rev : fifo_data;
    wire [7:0] status = {4'h0, !pix_ready, !fifo_valid, fs_kept, ls_kept};
    wire status_hit = (reg_addr == `OFF_STATUS);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            frame_sync_pin <= 1'b0;
            line_sync_pin <= 1'b0;
            data_pin <= 12'h000;
        end
        else if (pclk_rise)
        begin
            frame_sync_pin <= next_fs;
            line_sync_pin <= next_ls;
            data_pin <= (active_pix && fifo_valid) ? next_data : 12'h000;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pixclk_pin <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            pixclk_pin <= !clock_kill && (pclk_sync ^ pclk_invert);
            reg_rdata <= status_hit ? status : rd_chain[SLOTS];
        end
    end

    // *****************************************************************
    // checks
    // *****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_line_end;
        pclk_rise && col_wrap && !row_wrap;
    endsequence
    sequence s_pop_swapped;
        pclk_rise && active_pix && fifo_valid && swap;
    endsequence

    property p_kill_stops_clock;
        clock_kill |=> !pixclk_pin;
    endproperty
    a_kill_stops_clock: assert property (p_kill_stops_clock)
        else $error("pixel clock pad toggles while killed");

    property p_clock_phase;
        pclk_rise && !clock_kill |=> pixclk_pin == !$past(pclk_invert);
    endproperty
    a_clock_phase: assert property (p_clock_phase)
        else $error("pixel clock pad phase wrong");

    property p_fs_pad_off;
        reg_write && reg_addr == `OFF_PAD_CTRL && !reg_wdata[`BIT_FS_EN]
            |=> !frame_sync_pin_oe;
    endproperty
    a_fs_pad_off: assert property (p_fs_pad_off)
        else $error("frame sync pad still enabled");

    property p_data_pad_low;
        reg_write && reg_addr == `OFF_DATA_EN_LO
            |=> data_pin_oe[3:0] == $past(reg_wdata[7:4]);
    endproperty
    a_data_pad_low: assert property (p_data_pad_low)
        else $error("low data pad enables wrong");

    property p_fs_suppressed;
        pclk_rise && work.suppress[0] |=> frame_sync_pin == $past(work.fs_inv);
    endproperty
    a_fs_suppressed: assert property (p_fs_suppressed)
        else $error("suppressed frame sync became active");

    property p_ls_blank;
        pclk_rise && vblank && !work.in_blank
            |=> line_sync_pin == $past(work.ls_inv);
    endproperty
    a_ls_blank: assert property (p_ls_blank)
        else $error("line sync active in blanking");

    property p_deferred;
        reg_write && reg_addr == `OFF_SUPPRESS && !cfg_load
            |=> work == $past(work);
    endproperty
    a_deferred: assert property (p_deferred)
        else $error("sync setting applied before frame end");

    property p_col_wrap;
        s_line_end |=> col == 13'h0000 && row == $past(row) + 13'h0001;
    endproperty
    a_col_wrap: assert property (p_col_wrap)
        else $error("counters did not wrap to next row");

    property p_fs_start;
        pclk_rise && pos == fs_begin && work.suppress == 2'b00
            |=> frame_sync_pin != $past(work.fs_inv);
    endproperty
    a_fs_start: assert property (p_fs_start)
        else $error("frame sync missing at start point");

    property p_swap;
        s_pop_swapped |=> data_pin == $past(data_rev);
    endproperty
    a_swap: assert property (p_swap)
        else $error("data bit order not reversed");
endmodule
`default_nettype wire

// ### bench/capture_model.sv
// host capture model: samples the video pins at each output clock rise
`timescale 1ns/1ns
`default_nettype none
module capture_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clear,
    // video pins
    input wire logic frame_sync_pin,
    input wire logic frame_sync_pin_oe,
    input wire logic line_sync_pin,
    input wire logic line_sync_pin_oe,
    input wire logic pixclk_pin,
    input wire logic pixclk_pin_oe,
    input wire logic [11:0] data_pin,
    // what was received
    output logic [15:0] tick_count,
    output logic [15:0] fs_count,
    output logic [15:0] ls_count,
    output logic [15:0] cap_count,
    output logic [11:0] words [16]
);
    logic clk_last;
    logic fs_seen;
    logic ls_seen;
    logic clk_seen;
    // a pad that is not driven reads as inactive, no pull on these lines
    assign fs_seen = frame_sync_pin_oe & frame_sync_pin;
    assign ls_seen = line_sync_pin_oe & line_sync_pin;
    assign clk_seen = pixclk_pin_oe & pixclk_pin;
    always_ff @(posedge core_clk)
    begin
        clk_last <= clk_seen;
        if (srst || clear)
        begin
            tick_count <= '0;
            fs_count <= '0;
            ls_count <= '0;
            cap_count <= '0;
        end
        else if (clk_seen && !clk_last)
        begin
            tick_count <= tick_count + 16'h0001;
            fs_count <= fs_count + {15'h0000, fs_seen};
            ls_count <= ls_count + {15'h0000, ls_seen};
            // only words inside both sync windows are pixels
            if (fs_seen && ls_seen)
            begin
                if (cap_count < 16'h0010)
                    words[cap_count[3:0]] <= data_pin;
                cap_count <= cap_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/test_parallel_sync_output.sv
// self-checking bench of the parallel sync output block
`timescale 1ns/1ns
`default_nettype none
module test_parallel_sync_output;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic pixclk_in = 1'b0;
    logic pclk_run = 1'b1;
    logic pix_valid = 1'b0;
    logic [11:0] pix_data = 12'h000;
    logic clear = 1'b0;
    logic [7:0] reg_rdata;
    logic pix_ready, fs, fs_oe, ls, ls_oe, pk, pk_oe;
    logic [11:0] data_pin, data_pin_oe;
    sync_out_pkg::pad_ctrl_s pad_ctrl;
    logic [15:0] tick_count, fs_count, ls_count, cap_count;
    logic [11:0] words [16];
    int failures = 0;
    int tests_run = 0;
    // address, reset value, writable mask; 0x50 is unmapped
    logic [23:0] tab [21] = '{24'h210077, 24'h220070, 24'h270008,
        24'h2800FF, 24'h2900FE, 24'h2A00FF, 24'h2B00F0, 24'h2C0077,
        24'h2D0077, 24'h2E0077, 24'h2F0077, 24'h300077, 24'h69001F,
        24'h6A0DFF, 24'h6B031F, 24'h6CDDFF, 24'h6D001F, 24'h6E02FF,
        24'h860060, 24'h870070, 24'h500000};
    // suppress byte, mode byte, frame and line sync ticks per frame
    // the last case restores plain syncs for the pixel runs
    logic [39:0] cases [8] = '{40'h000002E012, 40'h2000000012,
        40'h400002E000, 40'h6000000000, 40'h002002E03C,
        40'h005007208E, 40'h401002E0A0, 40'h000002E012};

    always #25 core_clk = ~core_clk;
    // offset so pixel clock edges never meet core edges
    initial
    begin
        #13;
        forever #200 pixclk_in = pclk_run ? ~pixclk_in : 1'b0;
    end

    parallel_sync_output #(.FRAME_LAST_COL(13'h000F),
        .FRAME_LAST_ROW(13'h0009), .LINE_ACTIVE_COLS(13'h0006),
        .FIFO_DEPTH(8)) parallel_sync_output_i (.core_clk(core_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_rdata(reg_rdata),
        .pixclk_in(pixclk_in), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data),
        .frame_sync_pin(fs), .frame_sync_pin_oe(fs_oe),
        .line_sync_pin(ls), .line_sync_pin_oe(ls_oe), .pixclk_pin(pk),
        .pixclk_pin_oe(pk_oe), .data_pin(data_pin),
        .data_pin_oe(data_pin_oe), .pad_ctrl(pad_ctrl));
    capture_model capture_model_i (.core_clk(core_clk), .srst(srst),
        .clear(clear), .frame_sync_pin(fs), .frame_sync_pin_oe(fs_oe),
        .line_sync_pin(ls), .line_sync_pin_oe(ls_oe), .pixclk_pin(pk),
        .pixclk_pin_oe(pk_oe), .data_pin(data_pin),
        .tick_count(tick_count), .fs_count(fs_count),
        .ls_count(ls_count), .cap_count(cap_count), .words(words));

    // ********************
    // access tasks
    // ********************
    task automatic end_of_test;
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        repeat (2) @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic ticks(input int n);
        int t;
        int k;
        t = tick_count + n;
        for (k = 0; k < n * 12 + 40 && tick_count < t; k++)
            @(negedge core_clk);
        if (tick_count < t)
        begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic restart;
        @(negedge core_clk);
        clear = 1'b1;
        @(negedge core_clk);
        clear = 1'b0;
    endtask

    // ********************
    // scenarios
    // ********************
    initial
    begin
        int i, k, n;
        logic [7:0] d;
        logic [11:0] w;
        logic rdy;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        for (i = 0; i < 21; i++)
        begin
            rd(tab[i][23:16], d);
            check("reset value", d, tab[i][15:8]);
            wr(tab[i][23:16], 8'hFF);
            rd(tab[i][23:16], d);
            check("writable bits", d, tab[i][7:0]);
            wr(tab[i][23:16], 8'h00);
        end
        wr(8'h29, 8'hD8);
        wr(8'h2A, 8'hA5);
        wr(8'h2B, 8'h50);
        wr(8'h2C, 8'h57);
        wr(8'h28, 8'hE9);
        @(negedge core_clk);
        check("sync pad enables", {fs_oe, ls_oe, pk_oe}, 3'b111);
        check("data pad enables", data_pin_oe, 12'hA55);
        check("data drive", pad_ctrl.data_strength, 2'h3);
        check("clock drive", pad_ctrl.pixclk_strength, 2'h2);
        check("line drive", pad_ctrl.line_sync_strength, 2'h2);
        check("clock delay", pad_ctrl.pixclk_delay, 4'h9);
        check("line delay", pad_ctrl.line_sync_delay, 3'h5);
        check("data delay", pad_ctrl.data_delay[11], 3'h7);
        wr(8'h2A, 8'hFF);
        wr(8'h2B, 8'hF0);
        wr(8'h6A, 8'h02);
        wr(8'h6C, 8'h04);
        wr(8'h6E, 8'h02);
        wr(8'h29, 8'h98);
        for (i = 0; i < 8; i++)
        begin
            wr(8'h86, cases[i][39:32]);
            wr(8'h87, cases[i][31:24]);
            // new settings land only at the end of a frame
            ticks(170);
            restart();
            ticks(160);
            check("frame sync", fs_count, cases[i][23:12]);
            check("line sync", ls_count, cases[i][11:0]);
        end
        for (i = 0; i < 2; i++)
        begin
            wr(8'h29, i ? 8'h9A : 8'h98);
            pclk_run = 1'b0;
            repeat (20) @(negedge core_clk);
            restart();
            n = 0;
            pix_valid = 1'b1;
            for (k = 0; k < 10; k++)
            begin
                pix_data = 12'h5A0 + n;
                rdy = pix_ready;
                @(negedge core_clk);
                n += rdy;
            end
            pix_valid = 1'b0;
            check("words taken", n, 16'h0008);
            pclk_run = 1'b1;
            ticks(170);
            check("words seen", cap_count > 16'h0008, 1'b1);
            for (k = 0; k < 8; k++)
            begin
                w = 12'h5A0 + k;
                if (i)
                    w = {<<{w}};
                check("pixel word", words[k], w);
            end
            check("empty pixel", words[8], 12'h000);
        end
        pclk_run = 1'b0;
        repeat (20) @(negedge core_clk);
        wr(8'h29, 8'h9C);
        repeat (4) @(negedge core_clk);
        check("clock phase", pk, 1'b1);
        wr(8'h27, 8'h08);
        repeat (4) @(negedge core_clk);
        check("clock killed", pk, 1'b0);
        pclk_run = 1'b1;
        restart();
        repeat (100) @(negedge core_clk);
        check("ticks killed", tick_count, 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
